// [common/epfe_defines.vh]
// Constants for the serial EEPROM SPI slave front end.
// Assumes inclusion by bare name from design files.
`ifndef EPFE_DEFINES_VH
`define EPFE_DEFINES_VH

// Status byte field positions
`define EPFE_ST_BUSY      0
`define EPFE_ST_WEL       1
`define EPFE_ST_BP_LO     2
`define EPFE_ST_BP_HI     3
`define EPFE_ST_PPE       7

// Opcode decode: upper nibble zero, bit 3 ignored, low three bits
`define EPFE_OP_HI_MASK   8'hF0
`define EPFE_OP_LO_MASK   8'h07
`define EPFE_OP_WREN      8'h06
`define EPFE_OP_WRDI      8'h04
`define EPFE_OP_STATUS_READ_COMMAND      8'h05
`define EPFE_OP_WRSR      8'h01
`define EPFE_OP_READ      8'h03
`define EPFE_OP_WRITE     8'h02

// Reset and shipped values
`define EPFE_BYTE_ZERO    8'h00
`define EPFE_ERASED_BYTE  8'hFF
`define EPFE_BIT_LAST     3'h7
`define EPFE_BIT_FIRST    3'h0

// Power-up wait seen by the master, in microseconds
`define EPFE_PUP_TIME_US  100
`define EPFE_CLK_MHZ      100

`endif

// [logic/epfe_sync2.v]
// Two-flop synchroniser for asynchronous pin levels.
// Assumes one clock; first flop is read only by the second.
module epfe_sync2 #(
    parameter RST_VAL = 1'b0
) (
    input  wire i_clk,
    input  wire i_rst_b,
    input  wire i_async,
    output wire o_sync
);
    reg meta_q;
    reg sync_q;

    // Second stage alone feeds logic
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// [logic/epfe_slave.v]
// SPI slave front end of a serial EEPROM: framing, opcode capture,
// status read-out and power-up state of the status bits.
// Assumes SPI pins are asynchronous and oversampled by i_clk, which
// must run several times faster than the serial clock.
`include "epfe_defines.vh"

module epfe_slave (
    input  wire       i_clk,
    input  wire       i_rst_b,
    input  wire       i_por_b,
    input  wire       i_cs_b,
    input  wire       i_sck,
    input  wire       i_si,
    output reg        o_so,
    output wire       o_so_oe_b,
    input  wire [2:0] i_nv_prot,
    input  wire       i_busy,
    output wire       o_write_enable_latch,
    output wire       o_protect_pin_enable,
    output wire       o_block_protect_hi,
    output wire       o_block_protect_lo,
    output wire       o_standby,
    output reg  [7:0] o_opcode,
    output reg        o_opcode_vld,
    output reg        o_opcode_bad,
    output reg  [7:0] o_rx_byte,
    output reg        o_rx_vld,
    input  wire [7:0] i_tx_byte,
    output reg        o_tx_req
);
    localparam ST_IDLE = 2'b00;
    localparam ST_OPC  = 2'b01;
    localparam ST_DATA = 2'b10;
    localparam ST_DEAD = 2'b11;

    wire       cs_b_s;
    wire       sck_s;
    wire       si_s;
    wire       por_b_s;
    reg        sck_prev_q;
    reg        cs_prev_q;
    reg  [1:0] state_q;
    reg  [2:0] bit_q;
    reg  [7:0] sh_q;
    reg  [7:0] tx_q;
    reg        drive_q;
    reg        read_q;
    reg        wel_q;
    reg  [2:0] prot_q;
    reg        prot_loaded_q;

    // Pin levels cross into the clock domain
    epfe_sync2 #(.RST_VAL(1'b1)) u_cs (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_cs_b),
        .o_sync(cs_b_s));
    epfe_sync2 #(.RST_VAL(1'b0)) u_sck (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_sck),
        .o_sync(sck_s));
    epfe_sync2 #(.RST_VAL(1'b0)) u_si (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_si),
        .o_sync(si_s));
    epfe_sync2 #(.RST_VAL(1'b0)) u_por (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_por_b),
        .o_sync(por_b_s));

    wire sck_rise = sck_s & ~sck_prev_q;
    wire sck_fall = ~sck_s & sck_prev_q;
    wire cs_fall  = ~cs_b_s & cs_prev_q;
    wire selected = ~cs_b_s & por_b_s;

    // Opcode decode, bit 3 is a don't care
    function op_is;
        input [7:0] op;
        input [7:0] code;
        begin
            op_is = ((op & `EPFE_OP_HI_MASK) == `EPFE_BYTE_ZERO) &&
                    ((op & `EPFE_OP_LO_MASK) == code);
        end
    endfunction

    function op_known;
        input [7:0] op;
        begin
            op_known = op_is(op, `EPFE_OP_WREN) |
                       op_is(op, `EPFE_OP_WRDI) |
                       op_is(op, `EPFE_OP_STATUS_READ_COMMAND) |
                       op_is(op, `EPFE_OP_WRSR) |
                       op_is(op, `EPFE_OP_READ) |
                       op_is(op, `EPFE_OP_WRITE);
        end
    endfunction

    wire [7:0] shifted = {sh_q[6:0], si_s};
    wire [7:0] status  = {prot_q[2], 3'h0, prot_q[1], prot_q[0],
                          wel_q, i_busy};

    // Edge history; modes 0 and 3 use the same edges, the clock idle level is never looked at
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_b_s;
        end
    end

    // Protection bits stand for nonvolatile cells: loaded once after
    // power-on reset, never cleared by it
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prot_q        <= 3'h0;
            prot_loaded_q <= 1'b0;
        end else if (!prot_loaded_q && por_b_s) begin
            prot_q        <= i_nv_prot;
            prot_loaded_q <= 1'b1;
        end
    end

    // Serial framing state machine
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q      <= ST_IDLE;
            bit_q        <= `EPFE_BIT_FIRST;
            sh_q         <= `EPFE_BYTE_ZERO;
            tx_q         <= `EPFE_BYTE_ZERO;
            drive_q      <= 1'b0;
            read_q       <= 1'b0;
            wel_q        <= 1'b0;
            o_so         <= 1'b0;
            o_opcode     <= `EPFE_BYTE_ZERO;
            o_opcode_vld <= 1'b0;
            o_opcode_bad <= 1'b0;
            o_rx_byte    <= `EPFE_BYTE_ZERO;
            o_rx_vld     <= 1'b0;
            o_tx_req     <= 1'b0;
        end else begin
            o_opcode_vld <= 1'b0;
            o_opcode_bad <= 1'b0;
            o_rx_vld     <= 1'b0;
            o_tx_req     <= 1'b0;
            if (!por_b_s) begin
                state_q <= ST_IDLE;
                bit_q   <= `EPFE_BIT_FIRST;
                drive_q <= 1'b0;
                read_q  <= 1'b0;
                wel_q   <= 1'b0;
            end else if (!selected) begin
                state_q <= ST_IDLE;
                bit_q   <= `EPFE_BIT_FIRST;
                sh_q    <= `EPFE_BYTE_ZERO;
                drive_q <= 1'b0;
                read_q  <= 1'b0;
            end else begin
                case (state_q)
                ST_IDLE: begin
                    // Only a fresh select falling edge opens a frame
                    if (cs_fall) begin
                        state_q <= ST_OPC;
                    end
                end
                ST_OPC: begin
                    if (sck_rise) begin
                        sh_q  <= shifted;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == `EPFE_BIT_LAST) begin
                            o_opcode <= shifted;
                            if (op_known(shifted)) begin
                                o_opcode_vld <= 1'b1;
                                state_q      <= ST_DATA;
                                if (op_is(shifted, `EPFE_OP_WREN))
                                    wel_q <= 1'b1;
                                if (op_is(shifted, `EPFE_OP_WRDI))
                                    wel_q <= 1'b0;
                                if (op_is(shifted, `EPFE_OP_STATUS_READ_COMMAND)) begin
                                    read_q <= 1'b1;
                                    tx_q   <= status;
                                end
                                if (op_is(shifted, `EPFE_OP_READ)) begin
                                    read_q <= 1'b1;
                                    tx_q   <= i_tx_byte;
                                end
                            end else begin
                                o_opcode_bad <= 1'b1;
                                state_q      <= ST_DEAD;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (sck_rise) begin
                        sh_q  <= shifted;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == `EPFE_BIT_LAST) begin
                            o_rx_byte <= shifted;
                            o_rx_vld  <= ~read_q;
                        end
                    end
                    if (sck_fall && read_q) begin
                        drive_q <= 1'b1;
                        o_so    <= tx_q[7];
                        tx_q    <= {tx_q[6:0], 1'b0};
                        if (bit_q == `EPFE_BIT_LAST) begin
                            o_tx_req <= 1'b1;
                        end
                    end
                    // Reload at byte edge; status repeats while read
                    if (sck_rise && read_q &&
                        bit_q == `EPFE_BIT_LAST) begin
                        tx_q <= op_is(o_opcode, `EPFE_OP_STATUS_READ_COMMAND) ?
                                status : i_tx_byte;
                    end
                end
                default: begin
                    drive_q <= 1'b0;
                end
                endcase
            end
        end
    end

    // Output off unless selected and shifting a read
    assign o_so_oe_b = ~(drive_q & selected);

    assign o_write_enable_latch = wel_q;
    assign o_protect_pin_enable = prot_q[2];
    assign o_block_protect_hi   = prot_q[1];
    assign o_block_protect_lo   = prot_q[0];
    assign o_standby            = (state_q == ST_IDLE);
endmodule

// [verif/epfe_master.sv]
// Bus master model that frames traffic into the SPI slave front end.
// Assumes the bench calls its tasks just after rising clock edges.
module epfe_master (
    input  wire  i_clk,
    input  wire  i_so,
    input  wire  i_so_oe_b,
    output logic o_cs_b,
    output logic o_sck,
    output logic o_si
);
    timeunit 1ns;
    timeprecision 1ns;
    logic idle = 1'b0;
    logic so_q = 1'b0;
    // Released line shows the inverse of its last level, never a guess
    wire  so_line = i_so_oe_b ? ~so_q : i_so;
    initial begin
        o_cs_b = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b0;
    end
    // Keep the last driven level only, so a released line stays still
    always @(posedge i_clk) begin
        if (!i_so_oe_b) begin
            so_q <= i_so;
        end
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Idle level settles before select; only the master clocks
    task automatic sel(input logic mode);
        idle = mode;
        o_sck <= mode;
        wait_n(6);
        o_cs_b <= 1'b0;
        wait_n(6);
    endtask
    // Clock back to the same idle level before deselect
    task automatic desel();
        o_sck <= idle;
        wait_n(6);
        o_cs_b <= 1'b1;
        wait_n(6);
    endtask
    // MSb first; data set while low, SO sampled just before rise
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            o_sck <= 1'b0;
            o_si  <= tx[i];
            wait_n(6);
            rx[i] = so_line;
            o_sck <= 1'b1;
            wait_n(6);
        end
    endtask
endmodule

// [verif/epfe_slave_asserts.sv]
// Checker for the SPI slave front end, bound to its ports.
// Assumes frames with half periods of six clocks.
module epfe_slave_asserts (
    input wire       i_clk,
    input wire       i_rst_b,
    input wire       i_por_b,
    input wire       i_cs_b,
    input wire       i_sck,
    input wire [2:0] i_nv_prot,
    input wire       o_so,
    input wire       o_so_oe_b,
    input wire       o_write_enable_latch,
    input wire       o_protect_pin_enable,
    input wire       o_block_protect_hi,
    input wire       o_block_protect_lo,
    input wire       o_standby,
    input wire [7:0] o_opcode,
    input wire       o_opcode_vld,
    input wire       o_opcode_bad,
    input wire       o_rx_vld,
    input wire       o_tx_req
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Held long enough to pass the two-flop synchronisers
    sequence cs_idle; i_cs_b [*5]; endsequence
    sequence por_held; !i_por_b [*4]; endsequence
    desel_off_a: assert property (cs_idle |-> o_so_oe_b && !o_rx_vld)
        else $error("output active while deselected");
    desel_idle_a: assert property (cs_idle |-> o_standby)
        else $error("frame state left open after deselect");
    por_quiet_a: assert property (por_held |-> o_standby
        && !o_write_enable_latch && o_so_oe_b) else $error("active in reset");
    prot_load_a: assert property ($rose(i_por_b) |-> ##6
        ({o_protect_pin_enable, o_block_protect_hi, o_block_protect_lo}
        == $past(i_nv_prot, 6))) else $error("protect bits not kept");
    op_known_a: assert property (o_opcode_vld |-> o_opcode[7:4] == 4'h0
        && o_opcode[2:0] != 3'h0 && o_opcode[2:0] != 3'h7)
        else $error("unknown opcode accepted");
    bad_quiet_a: assert property (o_opcode_bad |=>
        (o_so_oe_b && !o_rx_vld && !o_opcode_vld) [*8])
        else $error("traffic after unknown opcode");
    read_oe_a: assert property ($fell(o_so_oe_b) |->
        o_opcode[2:0] == 3'h5 || o_opcode[2:0] == 3'h3)
        else $error("output driven for a non-read opcode");
    so_fall_a: assert property ((!o_so_oe_b && !$past(o_so_oe_b)
        && $changed(o_so)) |-> !$past(i_sck, 3) || !$past(i_sck, 4))
        else $error("output changed away from a falling edge");
    wel_set_a: assert property ((o_opcode_vld && o_opcode[2:0] == 3'h6)
        |-> ##[0:3] o_write_enable_latch) else $error("latch not set");
    tx_req_a: assert property (o_tx_req |-> !o_so_oe_b)
        else $error("next byte asked for while output off");
endmodule
bind epfe_slave epfe_slave_asserts chk (.i_clk, .i_rst_b, .i_por_b, .i_cs_b,
    .i_sck, .i_nv_prot, .o_so, .o_so_oe_b, .o_write_enable_latch,
    .o_protect_pin_enable, .o_block_protect_hi, .o_block_protect_lo,
    .o_standby, .o_opcode, .o_opcode_vld, .o_opcode_bad, .o_rx_vld,
    .o_tx_req);

// [verif/epfe_slave_test.sv]
// Self-checking bench for the SPI slave front end of the EEPROM.
// Assumes the master model and the checker are compiled first.
`include "epfe_defines.vh"
module epfe_slave_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0] op;
        logic       mode;
        logic       busy;
        logic       write_enable_latch;
        logic [7:0] st;
    } epfe_row_t;
    // Protection cells 1,0,1 give a status base of 8'h84
    // Read data is tied to 8'hA5; every data byte that frame sends is 8'h5A
    epfe_row_t  rows [11] = '{'{8'h06, 1'b0, 1'b0, 1'b1, 8'h00},
        '{8'h05, 1'b0, 1'b1, 1'b1, 8'h87}, '{8'h04, 1'b1, 1'b0, 1'b0, 8'h00},
        '{8'h0D, 1'b1, 1'b0, 1'b0, 8'h84}, '{8'h0E, 1'b0, 1'b0, 1'b1, 8'h00},
        '{8'h05, 1'b1, 1'b0, 1'b1, 8'h86}, '{8'h0C, 1'b0, 1'b0, 1'b0, 8'h00},
        '{8'h05, 1'b0, 1'b1, 1'b0, 8'h85}, '{8'h03, 1'b1, 1'b0, 1'b0, 8'hA5},
        '{8'h0A, 1'b0, 1'b0, 1'b0, 8'h00}, '{8'h01, 1'b1, 1'b0, 1'b0, 8'h00}};
    logic       i_clk = 1'b0;
    logic       i_rst_b = 1'b0;
    logic       i_por_b = 1'b0;
    logic       i_busy = 1'b0;
    logic [7:0] rx;
    int         checked = 0;
    int         n_mismatch = 0;
    int         n_rx = 0;
    wire [7:0]  rx_byte;
    wire        rx_vld;
    wire        cs_b, sck, si, so, so_oe_b, write_enable_latch, ppe, bp_hi, bp_lo, stby;
    epfe_slave dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_por_b(i_por_b),
        .i_cs_b(cs_b), .i_sck(sck), .i_si(si), .o_so(so),
        .o_so_oe_b(so_oe_b), .i_nv_prot(3'h5), .i_busy(i_busy),
        .o_write_enable_latch(write_enable_latch), .o_protect_pin_enable(ppe),
        .o_block_protect_hi(bp_hi), .o_block_protect_lo(bp_lo),
        .o_standby(stby), .o_opcode(), .o_opcode_vld(), .o_opcode_bad(),
        .o_rx_byte(rx_byte), .o_rx_vld(rx_vld), .i_tx_byte(8'hA5),
        .o_tx_req());
    epfe_master m (.i_clk(i_clk), .i_so(so), .i_so_oe_b(so_oe_b),
        .o_cs_b(cs_b), .o_sck(sck), .o_si(si));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [7:0] op, input logic mode);
        m.sel(mode);
        m.shift(op, 8, rx);
        m.shift(8'h5A, 8, rx);
        m.desel();
    endtask
    task automatic close_out();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    // Count data byte pulses; each one stands for a single cycle
    always @(posedge i_clk) begin
        if (rx_vld === 1'b1) begin
            n_rx <= n_rx + 1;
        end
    end
    // Run needs about 13000 cycles; a hang ends well past that
    initial begin
        repeat (30000) @(posedge i_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        cmp({5'h00, stby, write_enable_latch, so_oe_b}, 8'h05);
        cmp({5'h00, ppe, bp_hi, bp_lo}, 8'h00);
        frame(8'h06, 1'b0);
        cmp({7'h00, write_enable_latch}, 8'h00);
        i_por_b <= 1'b1;
        repeat (10) @(posedge i_clk);
        cmp({5'h00, ppe, bp_hi, bp_lo}, 8'h05);
        repeat (`EPFE_PUP_TIME_US * `EPFE_CLK_MHZ) @(posedge i_clk);
        $display("reset test done");
        foreach (rows[k]) begin
            i_busy <= rows[k].busy;
            frame(rows[k].op, rows[k].mode);
            if (rows[k].op[2:0] == 3'h5 || rows[k].op[2:0] == 3'h3) begin
                cmp(rx, rows[k].st);
            end else begin
                cmp(rx_byte, 8'h5A);
            end
            cmp({7'h00, write_enable_latch}, {7'h00, rows[k].write_enable_latch});
        end
        cmp(n_rx[7:0], 8'h06);
        $display("table test done");
        i_busy <= 1'b0;
        // Bytes after an unknown opcode must leave the latch alone
        m.sel(1'b0);
        m.shift(8'h16, 8, rx);
        m.shift(8'h06, 8, rx);
        cmp({7'h00, so_oe_b}, 8'h01);
        m.desel();
        cmp({7'h00, write_enable_latch}, 8'h00);
        $display("bad opcode test done");
        // Half a byte, then a select toggle without clocks
        m.sel(1'b1);
        m.shift(8'h06, 4, rx);
        m.desel();
        m.sel(1'b1);
        m.desel();
        frame(8'h05, 1'b1);
        cmp(rx, 8'h84);
        frame(8'h06, 1'b0);
        cmp({7'h00, write_enable_latch}, 8'h01);
        $display("soft reset test done");
        close_out();
    end
endmodule
